/* core/cer_regs.svh */
// register indices, field positions, reset values and counts of the block
`ifndef CER_REGS_SVH
`define CER_REGS_SVH

// register indices; the byte address is four times the index
`define CER_REFCTL_IDX     8'haf
`define CER_BCTL_IDX       8'h9f
`define CER_ISTAT_IDX      8'hb0
`define CER_IMASK_IDX      8'hb1

// reset values
`define CER_REFCTL_RST     8'h00
`define CER_BCTL_RST       8'hc0
`define CER_ISTAT_RST      8'h00
`define CER_IMASK_RST      8'h00

// field positions
`define CER_BCTL_FLAG_BIT  4
`define CER_ISTAT_EVT_BIT  0
`define CER_REG_WIDTH      8

// agreeing timer 1 samples needed before a debounced level is taken
`define CER_DEB_SAMPLES    2'h2

// axi responses
`define CER_RESP_OKAY      2'h0
`define CER_RESP_SLVERR    2'h2

`endif

/* core/cer_pkg.sv */
// types shared by the comparator event and reference control block
package cer_pkg;

   // interrupt mode of comparator b, listed in encoding order
   typedef enum logic [2:0] {
      CER_MODE_LOW_LEVEL,
      CER_MODE_RISE,
      CER_MODE_DEB_TOGGLE,
      CER_MODE_DEB_RISE,
      CER_MODE_FALL,
      CER_MODE_TOGGLE,
      CER_MODE_DEB_FALL,
      CER_MODE_HIGH_LEVEL
   } cer_irq_mode_t;

   // sampling clock source of a comparator
   typedef enum logic [1:0] {
      CER_CLK_SYS,
      CER_CLK_T0,
      CER_CLK_T1,
      CER_CLK_T2
   } cer_clk_sel_t;

   // negative input of a comparator
   typedef enum logic [1:0] {
      CER_NEG_PIN,
      CER_NEG_REF_LO,
      CER_NEG_REF_NOM,
      CER_NEG_REF_HI
   } cer_neg_sel_t;

   // comparator b control and status register
   typedef struct packed {
      logic [1:0]    pos_select;
      logic          input_connect;
      logic          irq_flag;
      logic          enable;
      cer_irq_mode_t irq_mode;
   } cer_bctl_t;

   // reference control register
   typedef struct packed {
      cer_clk_sel_t b_clock_select;
      cer_neg_sel_t b_neg_select;
      cer_clk_sel_t a_clock_select;
      cer_neg_sel_t a_neg_select;
   } cer_refctl_t;

endpackage

/* core/cer_sync.sv */
// three-stage synchroniser whose output moves when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module cer_sync (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic ce,
   input  wire logic din,
   output var  logic dout
);
   logic [2:0] stage_q;
   logic [2:0] stage_d;
   logic       dout_q;
   logic       dout_d;

   // shift the pin in; stage 0 feeds only stage 1
   always_comb begin
      stage_d = {stage_q[1:0], din};
      dout_d  = (stage_q[1] == stage_q[2]) ? stage_q[2] : dout_q;
   end

   // register the chain
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage_q <= 3'h0;
         dout_q  <= 1'b0;
      end else if (ce) begin
         stage_q <= stage_d;
         dout_q  <= dout_d;
      end
   end

   assign dout = dout_q;
endmodule
`default_nettype wire

/* core/cer_event.sv */
// comparator b sampling, debouncing and interrupt-mode event detection
`timescale 1ns/1ps
`default_nettype none
`include "cer_regs.svh"
module cer_event (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   ce,
   input  wire logic                   enable,
   input  wire logic                   sample_stb,
   input  wire logic                   t1_ovf,
   input  wire logic                   cmp_in,
   input  wire cer_pkg::cer_irq_mode_t mode,
   output var  logic                   cmp_out,
   output var  logic                   event_pulse
);
   logic       smp_q, smp_d;
   logic       smp_prev_q, smp_prev_d;
   logic       cand_q, cand_d;
   logic [1:0] agree_q, agree_d;
   logic       deb_q, deb_d;
   logic       deb_prev_q, deb_prev_d;
   logic       evt_q, evt_d;
   logic       hit;

   // sample, debounce on timer 1 overflow, detect the selected condition
   always_comb begin
      smp_d      = smp_q;
      cand_d     = cand_q;
      agree_d    = agree_q;
      deb_d      = deb_q;
      smp_prev_d = smp_q;
      deb_prev_d = deb_q;
      if (sample_stb)
         smp_d = cmp_in;
      if (t1_ovf) begin
         cand_d = smp_q;
         if (smp_q != cand_q)
            agree_d = 2'h1;
         else if (agree_q != `CER_DEB_SAMPLES)
            agree_d = agree_q + 2'h1;
         if (smp_q == cand_q && agree_q + 2'h1 >= `CER_DEB_SAMPLES)
            deb_d = smp_q;
      end
      case (mode)
         cer_pkg::CER_MODE_LOW_LEVEL:  hit = !smp_q;
         cer_pkg::CER_MODE_RISE:       hit = smp_q && !smp_prev_q;
         cer_pkg::CER_MODE_DEB_TOGGLE: hit = deb_q != deb_prev_q;
         cer_pkg::CER_MODE_DEB_RISE:   hit = deb_q && !deb_prev_q;
         cer_pkg::CER_MODE_FALL:       hit = !smp_q && smp_prev_q;
         cer_pkg::CER_MODE_TOGGLE:     hit = smp_q != smp_prev_q;
         cer_pkg::CER_MODE_DEB_FALL:   hit = !deb_q && deb_prev_q;
         default:                      hit = smp_q;
      endcase
      evt_d = enable && hit;
      if (!enable) begin
         smp_d      = 1'b0;
         smp_prev_d = 1'b0;
         cand_d     = 1'b0;
         agree_d    = 2'h0;
         deb_d      = 1'b0;
         deb_prev_d = 1'b0;
      end
   end

   // register detection state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         smp_q      <= 1'b0;
         smp_prev_q <= 1'b0;
         cand_q     <= 1'b0;
         agree_q    <= 2'h0;
         deb_q      <= 1'b0;
         deb_prev_q <= 1'b0;
         evt_q      <= 1'b0;
      end else if (ce) begin
         smp_q      <= smp_d;
         smp_prev_q <= smp_prev_d;
         cand_q     <= cand_d;
         agree_q    <= agree_d;
         deb_q      <= deb_d;
         deb_prev_q <= deb_prev_d;
         evt_q      <= evt_d;
      end
   end

   assign cmp_out     = smp_q;
   assign event_pulse = evt_q;
endmodule
`default_nettype wire

/* core/cer_top.sv */
// comparator b event logic and shared reference control behind axi4-lite
`timescale 1ns/1ps
`default_nettype none
`include "cer_regs.svh"
module cer_top #(
   parameter int ADDR_W = 12
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ce,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output var  logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output var  logic              s_axi_wready,
   output var  logic [1:0]        s_axi_bresp,
   output var  logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output var  logic              s_axi_arready,
   output var  logic [31:0]       s_axi_rdata,
   output var  logic [1:0]        s_axi_rresp,
   output var  logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // analog side and timers
   input  wire logic              cmp_b_raw,
   input  wire logic              t0_ovf,
   input  wire logic              t1_ovf,
   input  wire logic              t2_ovf,
   output var  logic              cmp_b_out,
   output var  logic              cmp_b_irq_flag,
   output var  logic              cmp_b_input_connect,
   output var  logic [3:0]        p2_input_only,
   output var  logic [1:0]        cmp_b_pos_select,
   output var  cer_pkg::cer_clk_sel_t cmp_b_clock_select,
   output var  cer_pkg::cer_neg_sel_t cmp_b_neg_select,
   output var  cer_pkg::cer_clk_sel_t cmp_a_clock_select,
   output var  cer_pkg::cer_neg_sel_t cmp_a_neg_select,
   output var  logic              irq
);

   // the highest register byte address must fit the address bus
   initial begin
      if (ADDR_W < 10 || ADDR_W > 32)
         $error("cer_top: ADDR_W must lie between 10 and 32");
   end

   // byte address of a register index
   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      logic [31:0] a;
      a = {22'h0, idx, 2'h0};
      return a[ADDR_W-1:0];
   endfunction

   // sample strobe of a comparator for its clock select
   function automatic logic clk_strobe(input cer_pkg::cer_clk_sel_t sel,
                                       input logic o0,
                                       input logic o1,
                                       input logic o2);
      logic s;
      case (sel)
         cer_pkg::CER_CLK_SYS: s = 1'b1;
         cer_pkg::CER_CLK_T0:  s = o0;
         cer_pkg::CER_CLK_T1:  s = o1;
         default:              s = o2;
      endcase
      return s;
   endfunction

   // register state
   cer_pkg::cer_bctl_t   bctl_q, bctl_d;
   cer_pkg::cer_refctl_t refctl_q, refctl_d;
   logic [7:0]          istat_q, istat_d;
   logic [7:0]          imask_q, imask_d;
   logic                irq_q, irq_d;

   // write channel state
   logic                aw_full_q, aw_full_d;
   logic [ADDR_W-1:0]   awaddr_q, awaddr_d;
   logic                w_full_q, w_full_d;
   logic [7:0]          wbyte_q, wbyte_d;
   logic                wlane_q, wlane_d;
   logic                awready_q, awready_d;
   logic                wready_q, wready_d;
   logic                bvalid_q, bvalid_d;
   logic [1:0]          bresp_q, bresp_d;

   // read channel state
   logic                arready_q, arready_d;
   logic                rvalid_q, rvalid_d;
   logic [31:0]         rdata_q, rdata_d;
   logic [1:0]          rresp_q, rresp_d;

   // internal nets
   logic                cmp_sync;
   logic                cmp_evt;
   logic                b_stb;
   logic                do_write;
   logic                do_read;
   logic                wr_bctl;
   logic                wr_refctl;
   logic                wr_imask;
   logic                wr_hit;
   logic                rd_istat;
   logic [7:0]          rd_byte;
   logic                rd_hit;

   // comparator output arrives from the analog domain
   cer_sync u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .din     (cmp_b_raw),
      .dout    (cmp_sync)
   );

   assign b_stb = clk_strobe(refctl_q.b_clock_select, t0_ovf, t1_ovf,
                             t2_ovf);

   cer_event u_event (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .ce          (ce),
      .enable      (bctl_q.enable),
      .sample_stb  (b_stb),
      .t1_ovf      (t1_ovf),
      .cmp_in      (cmp_sync),
      .mode        (bctl_q.irq_mode),
      .cmp_out     (cmp_b_out),
      .event_pulse (cmp_evt)
   );

   // write decode: both address and data held, response slot free
   always_comb begin
      do_write = aw_full_q && w_full_q && !bvalid_q;
      wr_bctl   = 1'b0;
      wr_refctl = 1'b0;
      wr_imask  = 1'b0;
      wr_hit    = 1'b1;
      if (awaddr_q == reg_addr(`CER_BCTL_IDX))
         wr_bctl = do_write && wlane_q;
      else if (awaddr_q == reg_addr(`CER_REFCTL_IDX))
         wr_refctl = do_write && wlane_q;
      else if (awaddr_q == reg_addr(`CER_IMASK_IDX))
         wr_imask = do_write && wlane_q;
      else if (awaddr_q == reg_addr(`CER_ISTAT_IDX))
         wr_hit = 1'b1;
      else
         wr_hit = 1'b0;
   end

   // write channel: take address and data in either order
   always_comb begin
      aw_full_d = aw_full_q;
      awaddr_d  = awaddr_q;
      w_full_d  = w_full_q;
      wbyte_d   = wbyte_q;
      wlane_d   = wlane_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      if (s_axi_awvalid && awready_q) begin
         aw_full_d = 1'b1;
         awaddr_d  = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
         w_full_d = 1'b1;
         wbyte_d  = s_axi_wdata[7:0];
         wlane_d  = s_axi_wstrb[0];
      end
      if (do_write) begin
         aw_full_d = 1'b0;
         w_full_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = wr_hit ? `CER_RESP_OKAY : `CER_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      awready_d = !aw_full_d && !bvalid_d;
      wready_d  = !w_full_d && !bvalid_d;
   end

   // read data mux
   always_comb begin
      rd_byte  = 8'h00;
      rd_hit   = 1'b1;
      rd_istat = 1'b0;
      if (s_axi_araddr == reg_addr(`CER_BCTL_IDX))
         rd_byte = bctl_q;
      else if (s_axi_araddr == reg_addr(`CER_REFCTL_IDX))
         rd_byte = refctl_q;
      else if (s_axi_araddr == reg_addr(`CER_ISTAT_IDX)) begin
         rd_byte  = istat_q;
         rd_istat = 1'b1;
      end else if (s_axi_araddr == reg_addr(`CER_IMASK_IDX))
         rd_byte = imask_q;
      else
         rd_hit = 1'b0;
   end

   // read channel: one read under way, answer one cycle after address
   always_comb begin
      do_read   = s_axi_arvalid && arready_q;
      rvalid_d  = rvalid_q;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      if (do_read) begin
         rvalid_d = 1'b1;
         rdata_d  = {24'h0, rd_byte};
         rresp_d  = rd_hit ? `CER_RESP_OKAY : `CER_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      arready_d = !rvalid_d;
   end

   // register file and interrupt; hardware set wins over any clear
   always_comb begin
      bctl_d   = bctl_q;
      refctl_d = refctl_q;
      imask_d  = imask_q;
      istat_d  = istat_q;
      if (wr_bctl) begin
         bctl_d = wbyte_q;
         // flag is cleared by writing zero, never set by software
         bctl_d.irq_flag = bctl_q.irq_flag &&
                           wbyte_q[`CER_BCTL_FLAG_BIT];
      end
      if (wr_refctl)
         refctl_d = wbyte_q;
      if (wr_imask)
         imask_d = wbyte_q;
      if (do_read && rd_istat)
         istat_d = 8'h00;
      if (cmp_evt) begin
         bctl_d.irq_flag = 1'b1;
         istat_d[`CER_ISTAT_EVT_BIT] = 1'b1;
      end
      irq_d = |(istat_d & imask_d);
   end

   // register all state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bctl_q    <= `CER_BCTL_RST;
         refctl_q  <= `CER_REFCTL_RST;
         istat_q   <= `CER_ISTAT_RST;
         imask_q   <= `CER_IMASK_RST;
         irq_q     <= 1'b0;
         aw_full_q <= 1'b0;
         awaddr_q  <= '0;
         w_full_q  <= 1'b0;
         wbyte_q   <= 8'h00;
         wlane_q   <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= 2'h0;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= 2'h0;
      end else if (ce) begin
         bctl_q    <= bctl_d;
         refctl_q  <= refctl_d;
         istat_q   <= istat_d;
         imask_q   <= imask_d;
         irq_q     <= irq_d;
         aw_full_q <= aw_full_d;
         awaddr_q  <= awaddr_d;
         w_full_q  <= w_full_d;
         wbyte_q   <= wbyte_d;
         wlane_q   <= wlane_d;
         awready_q <= awready_d;
         wready_q  <= wready_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         arready_q <= arready_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
   end

   // bus outputs
   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // analog control outputs taken from register fields, p2_input_only four copies of enable, and the registered interrupt
   assign cmp_b_irq_flag      = bctl_q.irq_flag;
   assign cmp_b_input_connect = bctl_q.input_connect;
   assign p2_input_only       = {4{bctl_q.enable}};
   assign cmp_b_pos_select    = bctl_q.pos_select;
   assign cmp_b_clock_select  = refctl_q.b_clock_select;
   assign cmp_b_neg_select    = refctl_q.b_neg_select;
   assign cmp_a_clock_select  = refctl_q.a_clock_select;
   assign cmp_a_neg_select    = refctl_q.a_neg_select;
   assign irq                 = irq_q;

endmodule
`default_nettype wire

/* tb/cer_chk_sva.sv */
// port assertions for the comparator event and reference block
`timescale 1ns/1ps
`default_nettype none
module cer_chk (
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready,
   input wire logic [31:0]           s_axi_rdata,
   input wire logic                  cmp_b_out,
   input wire logic                  cmp_b_irq_flag,
   input wire logic [3:0]            p2_input_only,
   input wire cer_pkg::cer_clk_sel_t cmp_b_clock_select
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // comparator side
   a_off_out_low: assert property (
      p2_input_only == 4'h0 && $past(p2_input_only) == 4'h0 |-> !cmp_b_out)
      else $error("output high while disabled");
   a_flag_needs_on: assert property (
      $rose(cmp_b_irq_flag) |-> p2_input_only[0] || $past(p2_input_only[0])
      || $past(p2_input_only[0], 2)) else $error("flag set while disabled");
   a_flag_sw_clear: assert property (
      $fell(cmp_b_irq_flag) |-> $rose(s_axi_bvalid))
      else $error("flag cleared without a write");
   a_sel_by_write: assert property (
      $changed(cmp_b_clock_select) |-> $rose(s_axi_bvalid))
      else $error("clock select moved without a write");
   // register bus side
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("no write response");
   a_bvalid_holds: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("no read data");
   a_rdata_holds: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && s_axi_rdata[31:8] == 24'h0) else $error("read data unstable");
   // main scenarios
   c_flag_clear: cover property (cmp_b_irq_flag ##1 !cmp_b_irq_flag);
   c_on_high: cover property (p2_input_only == 4'hf && cmp_b_out);
   c_rd_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind cer_top cer_chk u_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .cmp_b_out(cmp_b_out), .cmp_b_irq_flag(cmp_b_irq_flag),
   .p2_input_only(p2_input_only), .cmp_b_clock_select(cmp_b_clock_select));
`default_nettype wire

/* tb/cer_tb.sv */
// self-checking bench for the comparator event and reference block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
failures++; $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module tb;
   localparam logic [11:0] A_CTL = 12'h27c;
   localparam logic [11:0] A_REF = 12'h2bc;
   localparam logic [11:0] A_ST  = 12'h2c0;
   localparam logic [11:0] A_MSK = 12'h2c4;
   localparam logic [11:0] A_BAD = 12'h300;
   typedef struct packed {
      logic [11:0] a;
      logic [7:0]  d;
      logic [1:0]  r;
   } cer_row_t;
   typedef struct packed {
      logic [2:0] m;
      logic       a;
      logic       b;
      logic       t;
      logic       e;
   } cer_mrow_t;
   int                    failures = 0;
   int                    n_checks = 0;
   logic                  aclk = 1'b0;
   logic                  aresetn, awv, wv, brdy, arv, rrdy, raw, t0, t1;
   logic                  awr, wr_r, bv, arr, rv, cout, flag, conn, irq;
   logic [1:0]            bresp, rresp, pos, r;
   logic [3:0]            p2, wstrb;
   logic [11:0]           awaddr, araddr;
   logic [31:0]           wdata, rdata, d;
   logic [7:0]            ctl_e, ref_e;
   cer_pkg::cer_clk_sel_t bclk, aclks;
   cer_pkg::cer_neg_sel_t bneg, aneg;
   // pin changes follow clears of the connect bit
   cer_row_t  rows [7] = '{'{A_REF, 8'h1b, 2'h0}, '{A_REF, 8'he4, 2'h0},
      '{A_CTL, 8'h20, 2'h0}, '{A_CTL, 8'h00, 2'h0}, '{A_CTL, 8'h80, 2'h0},
      '{A_MSK, 8'h01, 2'h0}, '{A_BAD, 8'h5a, 2'h2}};
   cer_mrow_t mrows [11] = '{'{3'h0, 1'h1, 1'h0, 1'h1, 1'h1},
      '{3'h1, 1'h0, 1'h1, 1'h1, 1'h1}, '{3'h1, 1'h1, 1'h0, 1'h1, 1'h0},
      '{3'h2, 1'h1, 1'h0, 1'h1, 1'h1}, '{3'h3, 1'h0, 1'h1, 1'h1, 1'h1},
      '{3'h3, 1'h0, 1'h1, 1'h0, 1'h0}, '{3'h4, 1'h1, 1'h0, 1'h1, 1'h1},
      '{3'h4, 1'h0, 1'h1, 1'h1, 1'h0}, '{3'h5, 1'h0, 1'h1, 1'h1, 1'h1},
      '{3'h6, 1'h1, 1'h0, 1'h1, 1'h1}, '{3'h7, 1'h0, 1'h1, 1'h1, 1'h1}};
   cer_top dut (
      .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rrdy), .cmp_b_raw(raw), .t0_ovf(t0), .t1_ovf(t1),
      .t2_ovf(1'b0), .cmp_b_out(cout), .cmp_b_irq_flag(flag),
      .cmp_b_input_connect(conn), .p2_input_only(p2), .cmp_b_pos_select(pos),
      .cmp_b_clock_select(bclk), .cmp_b_neg_select(bneg),
      .cmp_a_clock_select(aclks), .cmp_a_neg_select(aneg), .irq(irq));
   // 125 MHz clock
   always #4 aclk = ~aclk;
   // verdict and end of run
   task automatic end_sim;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // bus write: address and data together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [7:0] v,
                     output logic [1:0] rs);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= {24'h0, v};
      awv <= 1'b1;
      wv <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awr) begin
            aw_ok = 1'b1;
            awv <= 1'b0;
         end
         if (!w_ok && wr_r) begin
            w_ok = 1'b1;
            wv <= 1'b0;
         end
      end
      brdy <= 1'b1;
      do @(posedge aclk); while (!bv);
      rs = bresp;
      brdy <= 1'b0;
   endtask
   // bus read; ready comes late so the data must stand
   task automatic rd(input logic [11:0] a, output logic [31:0] v,
                     output logic [1:0] rs);
      araddr <= a;
      arv <= 1'b1;
      do @(posedge aclk); while (!arr);
      arv <= 1'b0;
      @(posedge aclk);
      rrdy <= 1'b1;
      do @(posedge aclk); while (!rv);
      v = rdata;
      rs = rresp;
      rrdy <= 1'b0;
   endtask
   // read and compare data and response
   task automatic chkrd(input logic [11:0] a, input logic [7:0] e,
                        input string nm);
      rd(a, d, r);
      `CHK(nm, {(a == A_BAD) ? 2'h2 : 2'h0, 24'h0, e}, {r, d})
   endtask
   // timer 1 pulses every fourth cycle when asked
   task automatic settle(input logic t);
      repeat (12) begin
         t1 <= t;
         @(posedge aclk);
         t1 <= 1'b0;
         repeat (3) @(posedge aclk);
      end
   endtask
   // watchdog
   initial begin
      repeat (20000) @(posedge aclk);
      failures++;
      end_sim;
   end
   // main sequence
   initial begin
      {aresetn, awv, wv, brdy, arv, rrdy, raw, t0, t1} = 9'h0;
      {awaddr, araddr, wdata} = 56'h0;
      wstrb = 4'h1;
      ctl_e = 8'hc0;
      ref_e = 8'h00;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chkrd(A_CTL, 8'hc0, "ctl reset");
      chkrd(A_REF, 8'h00, "ref reset");
      `CHK("pins reset", 10'h300, {pos, conn, p2, flag, cout, irq})
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, r);
         `CHK("wr resp", rows[i].r, r)
         chkrd(rows[i].a, (rows[i].a == A_BAD) ? 8'h0 : rows[i].d, "reg");
         if (rows[i].a == A_CTL) ctl_e = rows[i].d;
         if (rows[i].a == A_REF) ref_e = rows[i].d;
         `CHK("ref fields", ref_e, {bclk, bneg, aclks, aneg})
         `CHK("ctl pins", {ctl_e[7:5], {4{ctl_e[3]}}}, {pos, conn, p2})
      end
      wr(A_REF, 8'h00, r);
      foreach (mrows[i]) begin
         raw <= mrows[i].a;
         wr(A_CTL, {5'h01, mrows[i].m}, r);
         settle(1'b1);
         wr(A_CTL, {5'h01, mrows[i].m}, r);
         rd(A_ST, d, r);
         `CHK("flag clear", 1'b0, flag)
         raw <= mrows[i].b;
         settle(mrows[i].t);
         `CHK("flag event", mrows[i].e, flag)
         `CHK("irq", {mrows[i].e, 4'hf}, {irq, p2})
         chkrd(A_ST, {7'h0, mrows[i].e}, "status");
      end
      wr(A_CTL, 8'h07, r);
      // a level event in the clearing cycle wins, so clear again once off
      wr(A_CTL, 8'h07, r);
      settle(1'b1);
      `CHK("off", 3'h0, {flag, cout, p2[0]})
      raw <= 1'b0;
      wr(A_REF, 8'h40, r);
      wr(A_CTL, 8'h0f, r);
      raw <= 1'b1;
      repeat (10) @(posedge aclk);
      `CHK("t0 idle", 2'h0, {cout, flag})
      t0 <= 1'b1;
      @(posedge aclk);
      t0 <= 1'b0;
      repeat (6) @(posedge aclk);
      `CHK("t0 sample", 2'h3, {cout, flag})
      wr(A_MSK, 8'h00, r);
      rd(A_ST, d, r);
      repeat (3) @(posedge aclk);
      `CHK("irq masked", 1'b0, irq)
      wr(A_MSK, 8'h01, r);
      repeat (3) @(posedge aclk);
      `CHK("irq on", 1'b1, irq)
      wr(A_CTL, 8'h07, r);
      repeat (4) @(posedge aclk);
      rd(A_ST, d, r);
      repeat (2) @(posedge aclk);
      `CHK("irq off", 1'b0, irq)
      wstrb <= 4'h0;
      wr(A_MSK, 8'h00, r);
      wstrb <= 4'h1;
      chkrd(A_MSK, 8'h01, "strobe off");
      end_sim;
   end
endmodule
`default_nettype wire
